// >>> hdl/dpot_i2c_slave.sv
/*
 Two-wire slave port of a dual digital potentiometer: bit engine on the
 link clock (scl), start/stop watch and nonvolatile store control on core_clk.
 Assumes an external master making every scl pulse, an open-drain sda wire
 resolved outside, and a nonvolatile cell driven by the nv_* outputs.

 // How it works
 // RULE1 - Start: sda falls while scl high
 // RULE2 - Stop: sda rises while scl high
 // RULE3 - Sda changes only with scl low
 // RULE4 - Send each bit on preceding falling edge
 // RULE5 - Ninth slot acknowledge, receiver pulls low
 // RULE6 - Released ninth slot means not-acknowledge
 // RULE7 - Eight bits MSB first plus acknowledge
 // RULE8 - Address is fixed nibble plus pins
 // RULE9 - Direction bit: zero write, one read
 // RULE10 - Mismatch: ignore everything until next start
 // RULE11 - Several data bytes per write allowed
 // RULE12 - Master checks acknowledge after each byte
 // RULE13 - Refuse address while store is busy
 // RULE14 - Store always rewrites all three bytes
 // RULE15 - Zero-crossing delays store start
 // RULE16 - Read order wiper0, wiper1, config, wrap
 // RULE17 - Single byte read gives wiper0
 // RULE18 - Master ends read with not-acknowledge
 // RULE19 - Master makes every scl pulse
 // RULE20 - Repeated start restarts address phase
 // RULE21 - Top bits 00/01 pick wiper
 // RULE22 - Top bits 10 write configuration
 // RULE23 - Stop starts store unless volatile
 // RULE24 - Enable pin high ignores bus
 // RULE25 - Sda only pulled low or released
 // RULE26 - Acknowledge matching address and accepted bytes
*/
`timescale 1ns/1ps

module dpot_sync #(
	parameter int W = 1
) (
	input wire logic clk, // Sampling clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic [W-1:0] d, // Foreign-domain input
	output logic [W-1:0] q // Synchronised output
);
	logic [W-1:0] meta_ff;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_ff <= '0;
			q <= '0;
		end
		else
		begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end
endmodule // dpot_sync

module dpot_i2c_slave #(
	parameter int NV_STORE_TIME_NS = dpot_pkg::NV_STORE_TIME_NS_DEF
) (
	input wire logic core_clk, // Core clock, 200 MHz
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic scl, // Link clock from the master
	input wire logic sda_i, // Sda wire level
	output logic sda_o, // Sda drive value, always low
	output logic sda_oe, // Sda pull-low enable
	input wire logic comm_en_n, // Communication enable, active low
	input wire logic addr_select_pin_0, // Address select pin 0
	input wire logic addr_select_pin_1, // Address select pin 1
	input wire logic addr_select_pin_2, // Address select pin 2
	input wire logic zc_done, // Zero-crossing detection complete
	output logic [5:0] wiper0_setting, // Live wiper 0 setting
	output logic [5:0] wiper1_setting, // Live wiper 1 setting
	output logic volatile_select, // Config: volatile mode
	output logic zero_cross_en, // Config: zero-crossing enable
	output logic tap_count_sel, // Config: tap count select
	output logic nv_busy, // Nonvolatile store in progress
	output logic nv_write_en, // Store strobe level to the cell
	output logic [5:0] nv_wiper0, // Stored wiper 0 value
	output logic [5:0] nv_wiper1, // Stored wiper 1 value
	output logic [2:0] nv_config // Stored configuration bits
);
	import dpot_pkg::*;

	localparam int NV_STORE_CYC_RAW = (NV_STORE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NV_STORE_CYC = (NV_STORE_CYC_RAW < 1) ? 1 : NV_STORE_CYC_RAW;
	localparam logic [STORE_CNT_W-1:0] STORE_LAST = STORE_CNT_W'(NV_STORE_CYC - 1);

	// ----------------------------------------
	// Core side: pin watch
	// ----------------------------------------
	logic scl_s, sda_s, ce_n_s, zc_s, sda_d_ff, idle_ff, link_rst_n;
	logic start_c, stop_c;

	dpot_sync #(.W(4)) u_pin_sync (
		.clk(core_clk),
		.rst_n(rst_n),
		.d({scl, sda_i, comm_en_n, zc_done}),
		.q({scl_s, sda_s, ce_n_s, zc_s})
	);

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			sda_d_ff <= 1'b1;
		else
			sda_d_ff <= sda_s;
	end

	assign start_c = ~ce_n_s & scl_s & sda_d_ff & ~sda_s; // see RULE1
	assign stop_c = ~ce_n_s & scl_s & ~sda_d_ff & sda_s; // see RULE2

	// Bus idle holds the link engine in reset; stop or disable releases sda
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			idle_ff <= 1'b1;
		else if (ce_n_s || stop_c) // see RULE24
			idle_ff <= 1'b1;
		else if (start_c)
			idle_ff <= 1'b0;
	end

	assign link_rst_n = rst_n & ~idle_ff;

	// ----------------------------------------
	// Link side: bit engine on scl
	// ----------------------------------------
	dpot_link_t phase_ff, nxt_phase;
	logic [3:0] bit_cnt_ff, nxt_bit_cnt;
	logic [7:0] shift_ff, tx_ff, nxt_tx, rd_byte;
	logic [1:0] rd_sel_ff, nxt_rd_sel;
	logic oe_ff, nxt_oe, start_det, wr_accept, busy_l, wr_tgl_ff;
	logic [2:0] addr_pins_s, cfg_ff;
	logic [5:0] wiper0_ff, wiper1_ff;

	dpot_sync #(.W(4)) u_link_sync (
		.clk(scl),
		.rst_n(rst_n),
		.d({nv_busy, addr_select_pin_2, addr_select_pin_1, addr_select_pin_0}),
		.q({busy_l, addr_pins_s})
	);

	// Every rising edge samples sda, MSB first
	always_ff @(posedge scl or negedge link_rst_n)
	begin
		if (!link_rst_n)
			shift_ff <= SHIFT_IDLE;
		else
			shift_ff <= {shift_ff[6:0], sda_i}; // see RULE3, RULE7
	end

	always_comb
	begin
		case (rd_sel_ff)
			SEL_WIPER0: rd_byte = {SEL_WIPER0, wiper0_ff};
			SEL_WIPER1: rd_byte = {SEL_WIPER1, wiper1_ff};
			default: rd_byte = {SEL_CONFIG, CFG_PAD, cfg_ff};
		endcase
	end

	// Sda high at the rise but low at the fall means a start inside the pulse
	assign start_det = shift_ff[0] & ~sda_i; // see RULE1, RULE20

	always_comb
	begin
		nxt_phase = phase_ff;
		nxt_oe = 1'b0; // see RULE25
		nxt_tx = {tx_ff[6:0], 1'b1};
		nxt_rd_sel = rd_sel_ff;
		wr_accept = 1'b0;
		nxt_bit_cnt = (bit_cnt_ff == BIT_ACK) ? BIT_FIRST : bit_cnt_ff + BIT_STEP;
		if (start_det)
		begin
			nxt_phase = LK_ADDR; // see RULE20
			nxt_rd_sel = SEL_WIPER0;
			nxt_bit_cnt = BIT_FIRST;
		end
		else
		begin
			case (phase_ff)
				LK_ADDR:
					if (bit_cnt_ff == BIT_LAST)
					begin
						if (shift_ff[7:1] == {ADDR_FIXED, addr_pins_s} && !busy_l) // see RULE8, RULE13
						begin
							nxt_oe = 1'b1; // see RULE26, RULE5
							nxt_phase = shift_ff[0] ? LK_READ : LK_WRITE; // see RULE9
						end
						else
							nxt_phase = LK_IGNORE; // see RULE10
					end
				LK_WRITE:
					if (bit_cnt_ff == BIT_LAST && shift_ff[7:6] != SEL_NONE)
					begin
						nxt_oe = 1'b1; // see RULE26, RULE11, RULE12
						wr_accept = 1'b1;
					end
				LK_READ:
					if (bit_cnt_ff == BIT_ACK)
					begin
						if (!shift_ff[0]) // see RULE5, RULE6, RULE18
						begin
							nxt_oe = ~rd_byte[7]; // see RULE4
							nxt_tx = {rd_byte[6:0], 1'b1};
							nxt_rd_sel = (rd_sel_ff == SEL_CONFIG) ? SEL_WIPER0
								: rd_sel_ff + SEL_STEP; // see RULE16, RULE17
						end
						else
							nxt_phase = LK_IGNORE;
					end
					else if (bit_cnt_ff < BIT_LAST)
						nxt_oe = ~tx_ff[7]; // see RULE4, RULE7
				default:
					nxt_oe = 1'b0;
			endcase
		end
	end

	// Falling edges advance the slot and change sda
	always_ff @(negedge scl or negedge link_rst_n)
	begin
		if (!link_rst_n)
		begin
			phase_ff <= LK_IGNORE;
			bit_cnt_ff <= BIT_FIRST;
			oe_ff <= 1'b0;
			tx_ff <= SHIFT_IDLE;
			rd_sel_ff <= SEL_WIPER0;
		end
		else
		begin
			phase_ff <= nxt_phase;
			bit_cnt_ff <= nxt_bit_cnt;
			oe_ff <= nxt_oe; // see RULE3, RULE19
			tx_ff <= nxt_tx;
			rd_sel_ff <= nxt_rd_sel;
		end
	end

	// Settings survive bus idle, so only the power reset touches them
	always_ff @(negedge scl or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wiper0_ff <= WIPER_RST;
			wiper1_ff <= WIPER_RST;
			cfg_ff <= CFG_RST;
			wr_tgl_ff <= 1'b0;
		end
		else if (wr_accept)
		begin
			wr_tgl_ff <= ~wr_tgl_ff;
			case (shift_ff[7:6])
				SEL_WIPER0: wiper0_ff <= shift_ff[5:0]; // see RULE21
				SEL_WIPER1: wiper1_ff <= shift_ff[5:0]; // see RULE21
				default: cfg_ff <= shift_ff[2:0]; // see RULE22
			endcase
		end
	end

	assign sda_o = 1'b0; // see RULE25
	assign sda_oe = oe_ff;
	assign wiper0_setting = wiper0_ff;
	assign wiper1_setting = wiper1_ff;
	assign volatile_select = cfg_ff[CFG_VOL_BIT];
	assign zero_cross_en = cfg_ff[CFG_ZC_BIT];
	assign tap_count_sel = cfg_ff[CFG_TAP_BIT];

	// ----------------------------------------
	// Core side: nonvolatile store
	// ----------------------------------------
	logic wr_tgl_s, wr_tgl_d_ff, pending_ff, launch;
	logic [5:0] w0_s, w1_s;
	logic [2:0] cfg_s;
	dpot_store_t store_ff;
	logic [STORE_CNT_W-1:0] cnt_ff;

	dpot_sync #(.W(16)) u_val_sync (
		.clk(core_clk),
		.rst_n(rst_n),
		.d({wr_tgl_ff, wiper0_ff, wiper1_ff, cfg_ff}),
		.q({wr_tgl_s, w0_s, w1_s, cfg_s})
	);

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			wr_tgl_d_ff <= 1'b0;
		else
			wr_tgl_d_ff <= wr_tgl_s;
	end

	// A byte landing with the stop still counts: set wins over clear
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			pending_ff <= 1'b0;
		else if (wr_tgl_s != wr_tgl_d_ff)
			pending_ff <= 1'b1;
		else if (stop_c)
			pending_ff <= 1'b0;
	end

	assign launch = stop_c & pending_ff & ~cfg_s[CFG_VOL_BIT]; // see RULE23

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			store_ff <= ST_IDLE;
			cnt_ff <= '0;
		end
		else
		begin
			case (store_ff)
				ST_IDLE:
					if (launch)
					begin
						cnt_ff <= '0;
						store_ff <= cfg_s[CFG_ZC_BIT] ? ST_ZC_WAIT : ST_WRITE; // see RULE15
					end
				ST_ZC_WAIT:
					if (zc_s)
						store_ff <= ST_WRITE; // see RULE15
				ST_WRITE:
					if (cnt_ff == STORE_LAST) // see RULE13
						store_ff <= ST_IDLE;
					else
						cnt_ff <= cnt_ff + 1'b1;
				default:
					store_ff <= ST_IDLE;
			endcase
		end
	end

	// Snapshot of all three bytes taken at launch
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			nv_wiper0 <= WIPER_RST;
			nv_wiper1 <= WIPER_RST;
			nv_config <= CFG_RST;
		end
		else if (store_ff == ST_IDLE && launch)
		begin
			nv_wiper0 <= w0_s; // see RULE14
			nv_wiper1 <= w1_s; // see RULE14
			nv_config <= cfg_s; // see RULE14
		end
	end

	assign nv_busy = (store_ff != ST_IDLE); // see RULE13
	assign nv_write_en = (store_ff == ST_WRITE);

endmodule // dpot_i2c_slave

// >>> hdl/dpot_pkg.sv
/*
 Constants, field layouts and state types of the dual wiper two-wire slave port.
 Assumes a 200 MHz core clock and a link clock that the bus master drives.
*/
package dpot_pkg;

	// ----------------------------------------
	// Clock and store timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int NV_STORE_TIME_NS_DEF = 10000000;
	localparam int STORE_CNT_W = 24;

	// ----------------------------------------
	// Address byte
	// ----------------------------------------
	localparam logic [3:0] ADDR_FIXED = 4'h5;

	// ----------------------------------------
	// Byte slots
	// ----------------------------------------
	localparam logic [3:0] BIT_FIRST = 4'h0;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_STEP = 4'h1;
	localparam logic [7:0] SHIFT_IDLE = 8'hFF;

	// ----------------------------------------
	// Data byte target select (top two bits)
	// ----------------------------------------
	localparam logic [1:0] SEL_WIPER0 = 2'h0;
	localparam logic [1:0] SEL_WIPER1 = 2'h1;
	localparam logic [1:0] SEL_CONFIG = 2'h2;
	localparam logic [1:0] SEL_NONE = 2'h3;
	localparam logic [1:0] SEL_STEP = 2'h1;

	// ----------------------------------------
	// Configuration bits
	// ----------------------------------------
	localparam int CFG_VOL_BIT = 2;
	localparam int CFG_ZC_BIT = 1;
	localparam int CFG_TAP_BIT = 0;
	localparam logic [2:0] CFG_PAD = 3'h0;
	localparam logic [2:0] CFG_RST = 3'h7;
	localparam logic [5:0] WIPER_RST = 6'h3F;

	typedef enum logic [1:0] {LK_IGNORE, LK_ADDR, LK_WRITE, LK_READ} dpot_link_t;
	typedef enum logic [1:0] {ST_IDLE, ST_ZC_WAIT, ST_WRITE} dpot_store_t;

endpackage

// >>> tb/dpot_i2c_slave_chk.sv
/*
 Port checker of the two-wire slave port, bound into dpot_i2c_slave.
 Assumes an open-drain sda resolved outside and scl idle high.
*/
`timescale 1ns/1ps

module dpot_i2c_slave_chk
	import dpot_pkg::*;
#(
	parameter int NV_STORE_TIME_NS = NV_STORE_TIME_NS_DEF
) (
	input wire logic core_clk, // Core clock
	input wire logic rst_n, // Reset
	input wire logic scl, // Link clock
	input wire logic sda_o, // Drive value
	input wire logic sda_oe, // Pull-low enable
	input wire logic comm_en_n, // Bus enable
	input wire logic zc_done, // Zero crossing
	input wire logic [5:0] wiper0_setting, // Wiper 0
	input wire logic [5:0] wiper1_setting, // Wiper 1
	input wire logic volatile_select, // Config 2
	input wire logic zero_cross_en, // Config 1
	input wire logic tap_count_sel, // Config 0
	input wire logic nv_busy, // Store busy
	input wire logic nv_write_en, // Store strobe
	input wire logic [5:0] nv_wiper0, // Stored wiper 0
	input wire logic [5:0] nv_wiper1, // Stored wiper 1
	input wire logic [2:0] nv_config // Stored config
);
	localparam int NCYC_RAW = (NV_STORE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NCYC = (NCYC_RAW < 1) ? 1 : NCYC_RAW;
	logic [STORE_CNT_W-1:0] wcnt_ff;

	// ----------------------------------------
	// Store strobe length counter
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			wcnt_ff <= '0;
		else if (nv_write_en)
			wcnt_ff <= wcnt_ff + 1'b1;
		else
			wcnt_ff <= '0;
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	AST_OD: assert property (sda_o == 1'b0) else $error("sda driven high");
	AST_CEN: assert property (comm_en_n [*4] |-> !sda_oe) else $error("sda pulled while off");
	AST_EDGE: assert property ($changed(sda_oe) |-> !scl) else $error("sda moved, scl high");
	AST_WIP: assert property (
		$changed(wiper0_setting) || $changed(wiper1_setting) |-> !scl)
		else $error("wiper moved, scl high");
	AST_BUSY: assert property (nv_write_en |-> nv_busy) else $error("strobe without busy");
	AST_END: assert property ($fell(nv_busy) |-> $past(nv_write_en))
		else $error("busy ended without store");
	AST_ZC: assert property (
		$rose(nv_write_en) && zero_cross_en |-> $past(zc_done, 2))
		else $error("store before zero crossing");
	AST_LEN: assert property ($fell(nv_write_en) |-> wcnt_ff == STORE_CNT_W'(NCYC))
		else $error("store strobe length");
	AST_SNAP: assert property ($rose(nv_busy) |-> nv_wiper0 == wiper0_setting
		&& nv_wiper1 == wiper1_setting
		&& nv_config == {volatile_select, zero_cross_en, tap_count_sel})
		else $error("store snapshot");
	AST_HOLD: assert property (
		nv_busy && $past(nv_busy) |-> $stable({nv_wiper0, nv_wiper1, nv_config}))
		else $error("snapshot moved");
	AST_NV: assert property ($rose(nv_busy) |-> !volatile_select && scl)
		else $error("store without stop");
endmodule // dpot_i2c_slave_chk

bind dpot_i2c_slave dpot_i2c_slave_chk #(.NV_STORE_TIME_NS(NV_STORE_TIME_NS)) u_chk (
	.core_clk(core_clk), .rst_n(rst_n), .scl(scl), .sda_o(sda_o), .sda_oe(sda_oe),
	.comm_en_n(comm_en_n), .zc_done(zc_done), .wiper0_setting(wiper0_setting),
	.wiper1_setting(wiper1_setting), .volatile_select(volatile_select),
	.zero_cross_en(zero_cross_en), .tap_count_sel(tap_count_sel), .nv_busy(nv_busy),
	.nv_write_en(nv_write_en), .nv_wiper0(nv_wiper0), .nv_wiper1(nv_wiper1),
	.nv_config(nv_config));

// >>> tb/dpot_i2c_slave_test.sv
/*
 Self-checking bench of the two-wire slave port with a master model.
 Assumes pins at 3'h5 and a store time parameter of 100 ns.
*/
`timescale 1ns/1ps

module dpot_i2c_slave_test;
	import dpot_pkg::*;
	logic core_clk, rst_n, scl, sda, m_low, sda_o, sda_oe, comm_en_n, zc_done;
	logic volatile_select, zero_cross_en, tap_count_sel, nv_busy, nv_write_en;
	logic [2:0] pins, nv_config;
	logic [5:0] wiper0_setting, wiper1_setting, nv_wiper0, nv_wiper1;
	int failures = 0;
	int n_compared = 0;
	assign sda = ~(m_low | sda_oe);

	dpot_mst u_mst (.scl(scl), .sda_low(m_low), .sda(sda));
	dpot_i2c_slave #(.NV_STORE_TIME_NS(100)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
		.scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .comm_en_n(comm_en_n),
		.addr_select_pin_0(pins[0]), .addr_select_pin_1(pins[1]), .addr_select_pin_2(pins[2]),
		.zc_done(zc_done), .wiper0_setting(wiper0_setting), .wiper1_setting(wiper1_setting),
		.volatile_select(volatile_select), .zero_cross_en(zero_cross_en),
		.tap_count_sel(tap_count_sel), .nv_busy(nv_busy), .nv_write_en(nv_write_en),
		.nv_wiper0(nv_wiper0), .nv_wiper1(nv_wiper1), .nv_config(nv_config));

	task automatic results();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e)
		begin
			failures++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wait_nv(input logic v);
		int i;
		for (i = 0; i < 9000 && nv_busy !== v; i++)
			@(negedge core_clk);
		if (i == 9000)
		begin
			failures++;
			results();
		end
	endtask
	task automatic adr(input logic rw, input logic [7:0] e); // Start plus own address
		logic a;
		u_mst.start();
		u_mst.wr({ADDR_FIXED, 3'h5, rw}, a);
		chk("adr ack", e, {7'h0, a});
	endtask

	task automatic t_write();
		logic a;
		logic [7:0] wd [4] = '{8'h15, 8'h6A, 8'h82, 8'hC0};
		adr(1'b0, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			u_mst.wr(wd[i], a);
			chk("data ack", {7'h0, i == 3}, {7'h0, a});
		end
		u_mst.stop();
		chk("wiper0", 8'h15, {2'h0, wiper0_setting});
		chk("wiper1", 8'h2A, {2'h0, wiper1_setting});
		chk("config", 8'h02, {5'h0, volatile_select, zero_cross_en, tap_count_sel});
		$display("t_write done");
	endtask
	task automatic t_store();
		wait_nv(1'b1);
		adr(1'b0, 8'h01);
		u_mst.stop();
		chk("write_en", 8'h00, {7'h0, nv_write_en});
		@(negedge core_clk);
		zc_done = 1'b1;
		wait_nv(1'b0);
		chk("nv_wiper0", 8'h15, {2'h0, nv_wiper0});
		chk("nv_wiper1", 8'h2A, {2'h0, nv_wiper1});
		chk("nv_config", 8'h02, {5'h0, nv_config});
		zc_done = 1'b0;
		adr(1'b0, 8'h00);
		u_mst.stop();
		$display("t_store done");
	endtask
	task automatic t_read();
		logic [7:0] d;
		logic [7:0] ex [4] = '{8'h15, 8'h6A, 8'h82, 8'h15};
		adr(1'b1, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			u_mst.rd(i == 3, d);
			chk("read", ex[i], d);
		end
		adr(1'b1, 8'h00);
		u_mst.rd(1'b1, d);
		chk("read one", 8'h15, d);
		u_mst.stop();
		$display("t_read done");
	endtask
	task automatic t_ignore();
		logic a;
		for (int p = 0; p < 2; p++)
		begin
			@(negedge core_clk);
			comm_en_n = (p == 1);
			u_mst.start();
			u_mst.wr({ADDR_FIXED, p == 1 ? 3'h5 : 3'h2, 1'b0}, a);
			chk("ignored adr", 8'h01, {7'h0, a});
			u_mst.wr(8'h00, a);
			chk("ignored data", 8'h01, {7'h0, a});
			u_mst.stop();
			@(negedge core_clk);
			comm_en_n = 1'b0;
			chk("wiper0 kept", 8'h15, {2'h0, wiper0_setting});
		end
		$display("t_ignore done");
	endtask
	task automatic t_vol();
		logic a;
		adr(1'b0, 8'h00);
		u_mst.wr(8'h86, a);
		chk("cfg ack", 8'h00, {7'h0, a});
		u_mst.stop();
		repeat (10) @(negedge core_clk);
		chk("no store", 8'h00, {7'h0, nv_busy});
		chk("volatile", 8'h01, {7'h0, volatile_select});
		adr(1'b0, 8'h00);
		u_mst.wr(8'h80, a);
		u_mst.wr(8'h07, a);
		chk("wiper0 ack", 8'h00, {7'h0, a});
		u_mst.stop();
		wait_nv(1'b1);
		wait_nv(1'b0);
		chk("nv_wiper0 nzc", 8'h07, {2'h0, nv_wiper0});
		chk("nv_wiper1 nzc", 8'h2A, {2'h0, nv_wiper1});
		chk("nv_config nzc", 8'h00, {5'h0, nv_config});
		$display("t_vol done");
	endtask

	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	initial
	begin
		rst_n = 1'b0;
		comm_en_n = 1'b0;
		pins = 3'h5;
		zc_done = 1'b0;
		repeat (12) @(posedge core_clk);
		@(negedge core_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge core_clk);
		t_write();
		t_store();
		t_read();
		t_ignore();
		t_vol();
		results();
	end
endmodule // dpot_i2c_slave_test

// >>> tb/dpot_mst.sv
/*
 Behavioural two-wire bus master, scl period 160 ns, scl still between frames.
 Assumes a pull-up on sda resolved by the bench.
*/
`timescale 1ns/1ps

module dpot_mst (
	output logic scl, // Link clock
	output logic sda_low, // Pull sda low
	input wire logic sda // Sda level
);
	localparam time Q = 40ns;
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic start();
		#1;
		sda_low = 1'b0;
		#Q scl = 1'b1;
		#Q sda_low = 1'b1;
		#Q scl = 1'b0;
		#Q;
	endtask
	task automatic stop();
		sda_low = 1'b1;
		#Q scl = 1'b1;
		#Q sda_low = 1'b0;
		#Q;
	endtask
	task automatic bit_x(input logic b, output logic r);
		sda_low = ~b;
		#Q scl = 1'b1;
		#Q r = sda;
		#Q scl = 1'b0;
		#Q;
	endtask
	task automatic wr(input logic [7:0] d, output logic ack_n);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], r);
		bit_x(1'b1, ack_n);
	endtask
	task automatic rd(input logic ack_n, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(1'b1, d[i]);
		bit_x(ack_n, r);
	endtask
endmodule // dpot_mst
